/* File: hw/nco_pkg.sv */
// Constants, register map and sine helper for the NCO block
package nco_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int FREQ_W  = 32;
   localparam int SREG_W  = 64;
   localparam int PHASE_W = 13;
   localparam int OUT_W   = 12;
   // Lowest accumulator bit that feeds the phase adder
   localparam int PH_LSB  = FREQ_W - PHASE_W;
   // ----------------------------------------------------------------
   // Pin pipeline delays in main clocks
   // ----------------------------------------------------------------
   localparam int HOLD_DLY = 4;
   localparam int WORD_TRANSFER_N_DLY = 4;
   localparam int LOAD_DLY = 5;
   localparam int PM_DLY   = 4;
   // Sample stages from the lookup on, three clocks from phase register to FIFO input
   localparam int SAMP_STAGES = 3;
   // ----------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_ACC   = 8'h04;
   localparam logic [7:0] ADDR_INREG = 8'h08;
   localparam logic [7:0] ADDR_FLO   = 8'h0C;
   localparam logic [7:0] ADDR_FHI   = 8'h10;
   localparam logic [7:0] ADDR_SAMP  = 8'h14;
   localparam int CTRL_SEL_BIT = 0;
   localparam int CTRL_MSB_BIT = 1;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // ----------------------------------------------------------------
   // Phase offsets and output format
   // ----------------------------------------------------------------
   localparam logic [1:0] PM_0   = 2'h0;
   localparam logic [1:0] PM_90  = 2'h1;
   localparam logic [1:0] PM_270 = 2'h2;
   localparam logic [1:0] PM_180 = 2'h3;
   localparam logic [11:0] OUT_MID = 12'h800;
   localparam logic [11:0] OUT_MIN = 12'h001;
   localparam logic [11:0] OUT_MAX = 12'hFFF;
   localparam logic [12:0] HALF_SPAN = 13'h1000;
   localparam logic [10:0] AMP_MAX  = 11'h7FF;
   localparam int AMP_SHIFT = 22;

   // Parabolic half-wave sine; trades spur level for no large table
   function automatic logic [11:0] sine_approx(input logic [12:0] ph);
      logic [11:0] x;
      logic [23:0] p;
      logic [34:0] m;
      logic [10:0] v;
      x = ph[11:0];
      p = 24'(x) * 24'(HALF_SPAN - 13'(x));
      m = 35'(p) * 35'(AMP_MAX);
      v = m[AMP_SHIFT +: 11];
      return ph[12] ? OUT_MID - 12'(v) : OUT_MID + 12'(v);
   endfunction
endpackage

/* File: hw/nco_sine_synthesizer.sv */
// NCO core with serial word load, AXI4-Lite registers and output FIFO
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Output sample FIFO
// ------------------------------------------------------------------
module nco_fifo #(
   parameter int W = 12,
   parameter int D = 4
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         ce,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } nco_fifo_state_type;
   nco_fifo_state_type s_q, s_d;
   logic push, pop;

   // Honest flags straight from the fill count
   assign in_ready  = s_q.cnt != (AW+1)'(D);
   assign out_valid = s_q.cnt != '0;
   assign out_data  = s_q.mem[s_q.rp];
   assign push = ce && in_valid && in_ready;
   assign pop  = ce && out_valid && out_ready;

   // Pointer wrap handles depths that are not a power of two
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp = (s_q.wp == AW'(D-1)) ? '0 : s_q.wp + 1'b1;
      end
      if (pop) begin
         s_d.rp = (s_q.rp == AW'(D-1)) ? '0 : s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule // nco_fifo

module nco_sine_synthesizer #(
   parameter int FIFO_DEPTH = 4
) (
   // Clock, reset, clock enable
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        ce,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Serial word load pins
   input  wire logic        serial_clk,
   input  wire logic        freq_serial_in,
   input  wire logic        shift_enable_n,
   // Accumulator control pins
   input  wire logic        accum_step_enable_n,
   input  wire logic        word_transfer_n,
   input  wire logic        accum_load_n,
   input  wire logic [1:0]  phase_mod_bits,
   // Sample stream out
   output logic [11:0]      sine_sample_out,
   output logic             sample_valid,
   input  wire logic        sample_ready
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                                  sel_low;
      logic                                  msb_first;
      logic [2:0]                            sclk_s;
      logic [1:0]                            sd_s;
      logic [1:0]                            shen_s;
      logic [nco_pkg::HOLD_DLY-1:0]          hold_dly;
      logic [nco_pkg::WORD_TRANSFER_N_DLY-1:0]          word_transfer_n_dly;
      logic [nco_pkg::LOAD_DLY-1:0]          load_dly;
      logic [nco_pkg::PM_DLY-1:0][1:0]       pm_dly;
      logic [nco_pkg::SREG_W-1:0]            freq;
      logic [nco_pkg::FREQ_W-1:0]            inreg;
      logic [nco_pkg::FREQ_W-1:0]            acc;
      logic [nco_pkg::PHASE_W-1:0]           phase;
      logic [nco_pkg::SAMP_STAGES-1:0][11:0] samp;
      logic                                  aw_got;
      logic [7:0]                            awaddr;
      logic                                  w_got;
      logic [31:0]                           wdata;
      logic [3:0]                            wstrb;
      logic                                  bvalid;
      logic [1:0]                            bresp;
      logic                                  rvalid;
      logic [31:0]                           rdata;
      logic [1:0]                            rresp;
   } nco_state_type;
   nco_state_type s_q, s_d;
   // Sample stages wake at mid-scale so no zero word reaches the FIFO
   localparam nco_state_type RST_STATE = '{
      samp: {nco_pkg::SAMP_STAGES{nco_pkg::OUT_MID}}, default: '0};

   logic        fifo_in_ready;
   logic        adv;
   logic        sclk_rise;
   logic        shift_go;
   logic        hold_act, word_transfer_n_act, load_act;
   logic [1:0]  pm_code;
   logic [12:0] pm_off;
   logic [31:0] sel_word;

   // ---------------------------------------------------------------
   // Derived terms
   // ---------------------------------------------------------------
   // A full FIFO stalls the whole oscillator so no sample is lost
   assign adv       = ce && fifo_in_ready;
   assign sclk_rise = s_q.sclk_s[1] && !s_q.sclk_s[2];
   assign shift_go  = sclk_rise && s_q.shen_s[1];
   assign hold_act  = s_q.hold_dly[nco_pkg::HOLD_DLY-1];
   assign word_transfer_n_act  = s_q.word_transfer_n_dly[nco_pkg::WORD_TRANSFER_N_DLY-1];
   assign load_act  = s_q.load_dly[nco_pkg::LOAD_DLY-1];
   assign pm_code   = s_q.pm_dly[nco_pkg::PM_DLY-1];
   // Word mux is combinational, so a switch adds no clock
   assign sel_word  = s_q.sel_low ? s_q.freq[31:0]
                                  : s_q.freq[63:32];

   // Quadrature code to quarter-cycle offset on the top bits
   always_comb begin
      case (pm_code)
         nco_pkg::PM_90:  pm_off = 13'h0800;
         nco_pkg::PM_180: pm_off = 13'h1000;
         nco_pkg::PM_270: pm_off = 13'h1800;
         default:         pm_off = 13'h0000;
      endcase
   end

   // AXI handshakes: one write and one read in flight
   assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
   assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // Synchronisers run on ce only so serial edges are not missed
      s_d.sclk_s = {s_q.sclk_s[1:0], serial_clk};
      s_d.sd_s   = {s_q.sd_s[0], freq_serial_in};
      s_d.shen_s = {s_q.shen_s[0], !shift_enable_n};
      if (shift_go) begin
         if (s_q.msb_first) begin
            s_d.freq = {s_q.freq[62:0], s_q.sd_s[1]};
         end else begin
            s_d.freq = {s_q.sd_s[1], s_q.freq[63:1]};
         end
      end
      // Pin delay lines double as two-stage synchronisers
      if (adv) begin
         s_d.hold_dly = {s_q.hold_dly[2:0], accum_step_enable_n};
         s_d.word_transfer_n_dly = {s_q.word_transfer_n_dly[2:0], !word_transfer_n};
         s_d.load_dly = {s_q.load_dly[3:0], !accum_load_n};
         s_d.pm_dly   = {s_q.pm_dly[2:0], phase_mod_bits};
         if (word_transfer_n_act) begin
            s_d.inreg = sel_word;
         end
         if (load_act) begin
            s_d.acc = s_q.inreg;
         end else if (!hold_act) begin
            s_d.acc = s_q.acc + s_q.inreg;
         end
         s_d.phase = s_q.acc[31:nco_pkg::PH_LSB] + pm_off;
         s_d.samp[0] = nco_pkg::sine_approx(s_q.phase);
         for (int k = 1; k < nco_pkg::SAMP_STAGES; k++) begin
            s_d.samp[k] = s_q.samp[k-1];
         end
      end
      // Write address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.aw_got && s_q.w_got) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = nco_pkg::RESP_OKAY;
         if (s_q.awaddr == nco_pkg::ADDR_CTRL) begin
            if (s_q.wstrb[0]) begin
               s_d.sel_low   = s_q.wdata[nco_pkg::CTRL_SEL_BIT];
               s_d.msb_first = s_q.wdata[nco_pkg::CTRL_MSB_BIT];
            end
         end else begin
            s_d.bresp = nco_pkg::RESP_DECERR;
         end
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      // Reads show live oscillator state
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = nco_pkg::RESP_OKAY;
         case (s_axi_araddr)
            nco_pkg::ADDR_CTRL:  s_d.rdata = {30'h0, s_q.msb_first,
                                              s_q.sel_low};
            nco_pkg::ADDR_ACC:   s_d.rdata = s_q.acc;
            nco_pkg::ADDR_INREG: s_d.rdata = s_q.inreg;
            nco_pkg::ADDR_FLO:   s_d.rdata = s_q.freq[31:0];
            nco_pkg::ADDR_FHI:   s_d.rdata = s_q.freq[63:32];
            nco_pkg::ADDR_SAMP:  s_d.rdata = {20'h0,
               s_q.samp[nco_pkg::SAMP_STAGES-1]};
            default: begin
               s_d.rdata = 32'h0;
               s_d.rresp = nco_pkg::RESP_DECERR;
            end
         endcase
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
   end

   // Clock enable low freezes every flip-flop
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= RST_STATE;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Output FIFO
   // ---------------------------------------------------------------
   nco_fifo #(
      .W (nco_pkg::OUT_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .ce        (ce),
      .in_valid  (ce),
      .in_ready  (fifo_in_ready),
      .in_data   (s_q.samp[nco_pkg::SAMP_STAGES-1]),
      .out_valid (sample_valid),
      .out_ready (sample_ready),
      .out_data  (sine_sample_out)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_word_transfer_n_delay: assert property (
      (reset_n && !word_transfer_n && adv) ##1 adv[*3] |=> word_transfer_n_act)
      else $error("transfer not active four clocks after pin");
   chk_hold_delay: assert property (
      (reset_n && accum_step_enable_n && adv) ##1 adv[*3] |=> hold_act)
      else $error("hold not active four clocks after pin");
   chk_load_delay: assert property (
      (reset_n && !accum_load_n && adv) ##1 adv[*4] |=> load_act)
      else $error("load not active five clocks after pin");
   chk_pm_delay: assert property (
      ((reset_n && adv) ##1 adv[*3]) |=> pm_code == $past(phase_mod_bits, 4))
      else $error("phase code not delayed four clocks");
   chk_acc_step: assert property (
      adv && !hold_act && !load_act
      |=> s_q.acc == $past(s_q.acc) + $past(s_q.inreg))
      else $error("accumulator did not step");
   chk_acc_load: assert property (
      adv && load_act |=> s_q.acc == $past(s_q.inreg))
      else $error("accumulator did not load input register");
   chk_acc_hold: assert property (
      adv && hold_act && !load_act |=> $stable(s_q.acc))
      else $error("accumulator moved while held");
   chk_shift_freeze: assert property (
      ce && !shift_go |=> $stable(s_q.freq))
      else $error("frequency register changed without shift");
   chk_shift_lsb: assert property (
      ce && shift_go && !s_q.msb_first
      |=> s_q.freq[63] == $past(s_q.sd_s[1]))
      else $error("LSB-first bit did not enter at the top");
   chk_word_select: assert property (
      adv && word_transfer_n_act && s_q.sel_low
      |=> s_q.inreg == $past(s_q.freq[31:0]))
      else $error("low word not selected");
   chk_sample_range: assert property (
      s_q.samp[0] >= nco_pkg::OUT_MIN)
      else $error("sample below offset binary floor");

   cov_word_load: cover property (adv && word_transfer_n_act);
   cov_quad_shift: cover property (adv && pm_code == nco_pkg::PM_270);
   cov_fifo_stall: cover property (ce && !fifo_in_ready);
   cov_msb_shift: cover property (shift_go && s_q.msb_first);
endmodule // nco_sine_synthesizer

`default_nettype wire

/* File: tb/nco_ser_host.sv */
// Serial word loader standing in for the external controller
`timescale 1ns/1ps
`default_nettype none

module nco_ser_host (
   // Serial load pins
   output logic serial_clk,
   output logic freq_serial_in,
   output logic shift_enable_n
);
   // ----------------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------------
   // Clock stands still between frames, register frozen
   initial begin
      serial_clk     = 1'h0;
      freq_serial_in = 1'h0;
      shift_enable_n = 1'h1;
   end

   // ----------------------------------------------------------------
   // One 32-bit frame, 48 ns bit period
   // ----------------------------------------------------------------
   // Data moves on the falling edge so it sits still for many main
   // clocks around each rise; frz pulses the clock with shift held off
   task automatic send(input logic [31:0] w, input logic msb,
                       input logic frz);
      int i;
      #7;
      shift_enable_n = frz;
      for (i = 0; i < 32; i++) begin
         freq_serial_in = msb ? w[31 - i] : w[i];
         #24 serial_clk = 1'h1;
         #24 serial_clk = 1'h0;
      end
      #24 shift_enable_n = 1'h1;
      // Released line must not keep looking like valid data
      freq_serial_in = ~freq_serial_in;
   endtask
endmodule // nco_ser_host

`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the NCO block
`timescale 1ns/1ps
`default_nettype none

module tb;
   // ----------------------------------------------------------------
   // Signals and stimulus tables
   // ----------------------------------------------------------------
   logic        clk, reset_n, ce;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, phase_mod_bits;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   wire         serial_clk, freq_serial_in, shift_enable_n;
   logic        accum_step_enable_n, word_transfer_n, accum_load_n;
   logic [11:0] sine_sample_out;
   logic        sample_valid, sample_ready;
   int          n_fail, checks;
   localparam logic [31:0] WA = 32'h0A3D70A5;
   localparam logic [31:0] WB = 32'h5E71C28B;
   localparam logic [31:0] WC = 32'hC3A50F69;
   typedef struct packed {
      logic [1:0]  pm;
      logic [11:0] smp;
   } nco_row_type;
   // Phase code beside the sample it gives from phase zero
   nco_row_type rows [4] = '{'{nco_pkg::PM_0, nco_pkg::OUT_MID},
      '{nco_pkg::PM_90, nco_pkg::OUT_MAX},
      '{nco_pkg::PM_270, nco_pkg::OUT_MIN},
      '{nco_pkg::PM_180, nco_pkg::OUT_MID}};

   // Main clock, 200 MHz
   initial clk = 1'h0;
   always #2.5 clk = ~clk;

   nco_sine_synthesizer #(.FIFO_DEPTH(4)) uut (
      .clk, .reset_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .serial_clk, .freq_serial_in,
      .shift_enable_n, .accum_step_enable_n, .word_transfer_n,
      .accum_load_n, .phase_mod_bits, .sine_sample_out, .sample_valid,
      .sample_ready);

   nco_ser_host host (.serial_clk, .freq_serial_in, .shift_enable_n);

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      if (n_fail == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Bounded wait; a hang counts as a failure and ends the run
   task automatic guard(inout int n);
      n++;
      if (n > 200) begin
         n_fail++;
         complete_run();
      end
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] r);
      int n;
      bit aw, w;
      @(posedge clk);
      n = 0;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         if (aw && s_axi_awready === 1'h1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'h0;
         end
         if (w && s_axi_wready === 1'h1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'h0;
         end
         guard(n);
      end while (aw || w || s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      check(s_axi_bresp, r);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int n;
      @(posedge clk);
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready === 1'h1)
            s_axi_arvalid <= 1'h0;
         guard(n);
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      check(s_axi_rdata, d);
      check(s_axi_rresp, r);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [11:0] prev;
      n_fail = 0;
      checks = 0;
      {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, accum_load_n} = 3'h1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
      {ce, sample_ready, accum_step_enable_n, word_transfer_n} = 4'hF;
      phase_mod_bits = 2'h0;
      tick(5);
      check(s_axi_awready, 1'h1);
      check(s_axi_bvalid, 1'h0);
      check(sample_valid, 1'h0);
      check(sine_sample_out, 12'h000);
      reset_n <= 1'h1;
      rd(nco_pkg::ADDR_CTRL, 32'h0, nco_pkg::RESP_OKAY);
      rd(nco_pkg::ADDR_ACC, 32'h0, nco_pkg::RESP_OKAY);
      tick(10);
      prev = nco_pkg::OUT_MID;
      // Output holds for at least four clocks after a code change, then settles
      foreach (rows[i]) begin
         phase_mod_bits <= rows[i].pm;
         for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            check(sine_sample_out, prev);
         end
         tick(12);
         check(sine_sample_out, rows[i].smp);
         prev = rows[i].smp;
      end
      phase_mod_bits <= 2'h0;
      // Refused and odd register accesses
      wr(nco_pkg::ADDR_ACC, 32'h1, 4'hF, nco_pkg::RESP_DECERR);
      rd(8'h18, 32'h0, nco_pkg::RESP_DECERR);
      wr(nco_pkg::ADDR_CTRL, 32'h3, 4'h0, nco_pkg::RESP_OKAY);
      rd(nco_pkg::ADDR_CTRL, 32'h0, nco_pkg::RESP_OKAY);
      // Serial loads in both bit orders, then a frozen burst
      host.send(WC, 1'h0, 1'h0);
      rd(nco_pkg::ADDR_FHI, WC, nco_pkg::RESP_OKAY);
      wr(nco_pkg::ADDR_CTRL, 32'h2, 4'hF, nco_pkg::RESP_OKAY);
      host.send(WB, 1'h1, 1'h0);
      host.send(WA, 1'h1, 1'h0);
      rd(nco_pkg::ADDR_FHI, WB, nco_pkg::RESP_OKAY);
      rd(nco_pkg::ADDR_FLO, WA, nco_pkg::RESP_OKAY);
      host.send(~WA, 1'h1, 1'h1);
      rd(nco_pkg::ADDR_FLO, WA, nco_pkg::RESP_OKAY);
      // Transfer with the word select swapped under it
      word_transfer_n <= 1'h0;
      tick(10);
      rd(nco_pkg::ADDR_INREG, WB, nco_pkg::RESP_OKAY);
      wr(nco_pkg::ADDR_CTRL, 32'h3, 4'hF, nco_pkg::RESP_OKAY);
      tick(10);
      rd(nco_pkg::ADDR_INREG, WA, nco_pkg::RESP_OKAY);
      word_transfer_n <= 1'h1;
      accum_load_n <= 1'h0;
      tick(10);
      accum_load_n <= 1'h1;
      tick(10);
      rd(nco_pkg::ADDR_ACC, WA, nco_pkg::RESP_OKAY);
      // Ten steps, then ten more with three clocks disabled
      accum_step_enable_n <= 1'h0;
      tick(10);
      accum_step_enable_n <= 1'h1;
      tick(12);
      rd(nco_pkg::ADDR_ACC, WA * 32'd11, nco_pkg::RESP_OKAY);
      accum_step_enable_n <= 1'h0;
      tick(3);
      ce <= 1'h0;
      tick(3);
      ce <= 1'h1;
      tick(7);
      accum_step_enable_n <= 1'h1;
      tick(12);
      rd(nco_pkg::ADDR_ACC, WA * 32'd21, nco_pkg::RESP_OKAY);
      // Full buffer freezes the oscillator, so a step pulse is missed
      sample_ready <= 1'h0;
      tick(20);
      check(sample_valid, 1'h1);
      accum_step_enable_n <= 1'h0;
      tick(10);
      accum_step_enable_n <= 1'h1;
      tick(20);
      sample_ready <= 1'h1;
      tick(20);
      rd(nco_pkg::ADDR_ACC, WA * 32'd21, nco_pkg::RESP_OKAY);
      // Running sine never leaves its range
      accum_step_enable_n <= 1'h0;
      for (int k = 0; k < 40; k++) begin
         @(posedge clk);
         check({31'h0, sine_sample_out == 12'h000}, 32'h0);
      end
      complete_run();
   end
endmodule // tb

`default_nettype wire
